// >>> rtl/rimb_pkg.sv
// constants, register map and serial states of the regulator irq mask bank
package rimb_pkg;

  // 7-bit serial target address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;

  // register offsets
  localparam logic [7:0] OFS_TOP2 = 8'h21;
  localparam logic [7:0] OFS_CONV = 8'h22;
  localparam logic [7:0] OFS_LIN  = 8'h23;

  // values after reset (top2 bit 0 comes from otp)
  localparam logic [6:0] TOP2_RST_HI = 7'h00;
  localparam logic [7:0] CONV_RST    = 8'hDD;
  localparam logic [7:0] LIN_RST     = 8'hDD;

  // writable bits; reserved bits read as zero
  localparam logic [7:0] CONV_WMASK = 8'hDD;
  localparam logic [7:0] LIN_WMASK  = 8'hDD;

  // field positions: rail fields shared by the converter and linear masks, then the top2 reset mask bit
  localparam int R1_FALL_BIT = 7;
  localparam int R1_RISE_BIT = 6;
  localparam int R1_ILIM_BIT = 4;
  localparam int R0_FALL_BIT = 3;
  localparam int R0_RISE_BIT = 2;
  localparam int R0_ILIM_BIT = 0;
  localparam int RST_MASK_BIT = 0;

  // serial bit counter limit
  localparam logic [2:0] BIT_LAST = 3'h7;

  // serial engine states
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_ACK_A = 9'h004,
    ST_WREG  = 9'h008,
    ST_ACK_W = 9'h010,
    ST_WDAT  = 9'h020,
    ST_RDAT  = 9'h040,
    ST_HACK  = 9'h080,
    ST_RLOAD = 9'h100
  } rimb_state_t;

endpackage

// >>> rtl/rimb_rail_evt.sv
// per-rail raw status tracking and masked event flags
`timescale 1ns/10ps
module rimb_rail_evt (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // analog comparator levels
  input  wire logic pg_valid_i,
  input  wire logic curlim_i,
  // mask bits
  input  wire logic fall_block_i,
  input  wire logic rise_block_i,
  input  wire logic curlim_block_i,
  // flag clears
  input  wire logic pg_clr_i,
  input  wire logic curlim_clr_i,
  // status and flags
  output logic      pg_raw_o,
  output logic      curlim_raw_o,
  output logic      pg_flag_o,
  output logic      curlim_flag_o
);

  logic pg_raw_reg, pg_raw_next;
  logic lim_raw_reg, lim_raw_next;
  logic pg_flag_reg, pg_flag_next;
  logic lim_flag_reg, lim_flag_next;
  logic fall_evt, rise_evt, lim_evt;

  // edges seen against last sampled raw state
  always_comb begin
    pg_raw_next  = ~pg_valid_i;
    lim_raw_next = curlim_i;
    fall_evt     = pg_raw_next & ~pg_raw_reg;
    rise_evt     = ~pg_raw_next & pg_raw_reg;
    lim_evt      = lim_raw_next & ~lim_raw_reg;
    // set beats clear so no event is lost
    pg_flag_next = (pg_flag_reg & ~pg_clr_i)
                 | (fall_evt & ~fall_block_i)
                 | (rise_evt & ~rise_block_i);
    lim_flag_next = (lim_flag_reg & ~curlim_clr_i)
                  | (lim_evt & ~curlim_block_i);
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pg_raw_reg   <= 1'b0;
      lim_raw_reg  <= 1'b0;
      pg_flag_reg  <= 1'b0;
      lim_flag_reg <= 1'b0;
    end else begin
      pg_raw_reg   <= pg_raw_next;
      lim_raw_reg  <= lim_raw_next;
      pg_flag_reg  <= pg_flag_next;
      lim_flag_reg <= lim_flag_next;
    end
  end

  assign pg_raw_o      = pg_raw_reg;
  assign curlim_raw_o  = lim_raw_reg;
  assign pg_flag_o     = pg_flag_reg;
  assign curlim_flag_o = lim_flag_reg;

endmodule

// >>> rtl/rimb_top.sv
// regulator irq mask bank: serial register target, masks and rail flags
`timescale 1ns/10ps
// What this block does
// - Top mask bit 0 blocks register-reset interrupt when 1; reset value from otp.
// - Register-reset mask bit reloads from otp at every reset.
// - Converter mask bit 7 blocks converter 1 power-good invalid events.
// - Converter mask bit 6 blocks converter 1 power-good valid events.
// - Converter mask bit 4 blocks converter 1 current-limit events.
// - Converter mask bit 3 blocks converter 0 power-good invalid events.
// - Converter mask bit 2 blocks converter 0 power-good valid events.
// - Converter mask bit 0 blocks converter 0 current-limit events.
// - Linear mask bit 7 blocks regulator 1 power-good invalid events.
// - Linear mask bit 6 blocks regulator 1 power-good valid events.
// - Masks gate only flags; raw status keeps following the rails.
// - Raw power-good reads 0 when output valid, 1 when invalid.
// - Linear mask bit 2 blocks regulator 0 power-good valid events.
module rimb_top (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // serial bus pins
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  // otp value of the register-reset mask
  input  wire logic otp_rst_mask_i,
  // register reset event
  input  wire logic reg_reset_evt_i,
  input  wire logic reset_reg_clr_i,
  // rail levels
  input  wire logic conv0_pg_valid_i,
  input  wire logic conv1_pg_valid_i,
  input  wire logic lin0_pg_valid_i,
  input  wire logic lin1_pg_valid_i,
  input  wire logic conv0_curlim_i,
  input  wire logic conv1_curlim_i,
  input  wire logic lin0_curlim_i,
  input  wire logic lin1_curlim_i,
  // flag clears
  input  wire logic conv0_pg_clr_i,
  input  wire logic conv1_pg_clr_i,
  input  wire logic lin0_pg_clr_i,
  input  wire logic lin1_pg_clr_i,
  input  wire logic conv0_curlim_clr_i,
  input  wire logic conv1_curlim_clr_i,
  input  wire logic lin0_curlim_clr_i,
  input  wire logic lin1_curlim_clr_i,
  // raw status
  output logic      conv0_pg_raw_o,
  output logic      conv1_pg_raw_o,
  output logic      lin0_pg_raw_o,
  output logic      lin1_pg_raw_o,
  output logic      conv0_curlim_raw_o,
  output logic      conv1_curlim_raw_o,
  output logic      lin0_curlim_raw_o,
  output logic      lin1_curlim_raw_o,
  // sticky interrupt flags
  output logic      conv0_pg_irq_flag_o,
  output logic      conv1_pg_irq_flag_o,
  output logic      lin0_pg_irq_flag_o,
  output logic      lin1_pg_irq_flag_o,
  output logic      conv0_curlim_irq_flag_o,
  output logic      conv1_curlim_irq_flag_o,
  output logic      lin0_curlim_irq_flag_o,
  output logic      lin1_curlim_irq_flag_o,
  output logic      reset_reg_irq_flag_o
);

  // register readback decode
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] t2,
                                          input logic [7:0] cv, input logic [7:0] ln);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      rimb_pkg::OFS_TOP2: d = t2;
      rimb_pkg::OFS_CONV: d = cv;
      rimb_pkg::OFS_LIN:  d = ln;
      default:            d = 8'h00;
    endcase
    return d;
  endfunction

  rimb_pkg::rimb_state_t state_reg, state_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       rw_reg, rw_next;
  logic       oe_reg, oe_next;
  logic       sdo_reg, sdo_next;
  logic       scl_q_reg, sda_q_reg;
  logic [7:0] top2_reg, top2_next;
  logic [7:0] conv_reg, conv_next;
  logic [7:0] lin_reg, lin_next;
  logic       rflag_reg, rflag_next;
  logic       wr_en;
  logic [7:0] rx_byte;
  logic [7:0] rd_data;
  logic       scl_rise, scl_fall, bus_start, bus_stop;
  logic [3:0] pg_valid, curlim, fall_blk, rise_blk, lim_blk;
  logic [3:0] pg_clr, lim_clr, pg_raw, lim_raw, pg_flag, lim_flag;

  // bus conditions; pins are already synchronous to clk_i
  assign scl_rise  = scl_i & ~scl_q_reg;
  assign scl_fall  = ~scl_i & scl_q_reg;
  assign bus_start = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
  assign bus_stop  = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  assign rd_data   = reg_read(ptr_reg, top2_reg, conv_reg, lin_reg);

  // serial target: address, pointer, auto-incremented data bytes
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    sdo_next   = 1'b0;
    wr_en      = 1'b0;
    rx_byte    = {sh_reg[6:0], sda_i};
    if (bus_stop) begin
      state_next = rimb_pkg::ST_IDLE;
      oe_next    = 1'b0;
    end else if (bus_start) begin
      state_next = rimb_pkg::ST_ADDR;
      cnt_next   = 3'h0;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        rimb_pkg::ST_ADDR, rimb_pkg::ST_WREG, rimb_pkg::ST_WDAT: begin
          if (scl_rise) begin
            sh_next  = rx_byte;
            cnt_next = 3'(cnt_reg + 3'h1);
            if (cnt_reg == rimb_pkg::BIT_LAST) begin
              if (state_reg == rimb_pkg::ST_ADDR) begin
                // a foreign address leaves the bus alone until next start
                if (rx_byte[7:1] == rimb_pkg::DEV_ADDR) begin
                  rw_next    = rx_byte[0];
                  state_next = rimb_pkg::ST_ACK_A;
                end else begin
                  state_next = rimb_pkg::ST_IDLE;
                end
              end else if (state_reg == rimb_pkg::ST_WREG) begin
                ptr_next   = rx_byte;
                state_next = rimb_pkg::ST_ACK_W;
              end else begin
                wr_en      = 1'b1;
                ptr_next   = 8'(ptr_reg + 8'h01);
                state_next = rimb_pkg::ST_ACK_W;
              end
            end
          end
        end
        rimb_pkg::ST_ACK_A, rimb_pkg::ST_ACK_W: begin
          if (scl_fall) begin
            if (!oe_reg) begin
              oe_next = 1'b1;
            end else begin
              oe_next  = 1'b0;
              cnt_next = 3'h0;
              if (state_reg == rimb_pkg::ST_ACK_W) begin
                state_next = rimb_pkg::ST_WDAT;
              end else if (rw_reg) begin
                sh_next    = rd_data;
                oe_next    = ~rd_data[7];
                state_next = rimb_pkg::ST_RDAT;
              end else begin
                state_next = rimb_pkg::ST_WREG;
              end
            end
          end
        end
        rimb_pkg::ST_RDAT: begin
          if (scl_fall) begin
            if (cnt_reg == rimb_pkg::BIT_LAST) begin
              oe_next    = 1'b0;
              state_next = rimb_pkg::ST_HACK;
            end else begin
              sh_next  = {sh_reg[6:0], 1'b0};
              oe_next  = ~sh_reg[6];
              cnt_next = 3'(cnt_reg + 3'h1);
            end
          end
        end
        rimb_pkg::ST_HACK: begin
          if (scl_rise) begin
            if (!sda_i) begin
              ptr_next   = 8'(ptr_reg + 8'h01);
              state_next = rimb_pkg::ST_RLOAD;
            end else begin
              state_next = rimb_pkg::ST_IDLE;
            end
          end
        end
        rimb_pkg::ST_RLOAD: begin
          if (scl_fall) begin
            sh_next    = rd_data;
            oe_next    = ~rd_data[7];
            cnt_next   = 3'h0;
            state_next = rimb_pkg::ST_RDAT;
          end
        end
        rimb_pkg::ST_IDLE: begin
          oe_next = 1'b0;
        end
        default: begin
          state_next = rimb_pkg::ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= rimb_pkg::ST_IDLE;
      cnt_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      sdo_reg   <= 1'b0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      oe_reg    <= oe_next;
      sdo_reg   <= sdo_next;
      scl_q_reg <= scl_i;
      sda_q_reg <= sda_i;
    end
  end

  // open drain: pin only ever pulled low
  assign sda_o    = sdo_reg;
  assign sda_oe_o = oe_reg;

  // mask registers and register-reset flag
  always_comb begin
    top2_next = top2_reg;
    conv_next = conv_reg;
    lin_next  = lin_reg;
    if (wr_en) begin
      case (ptr_reg)
        rimb_pkg::OFS_TOP2: top2_next = rx_byte;
        rimb_pkg::OFS_CONV: conv_next = rx_byte & rimb_pkg::CONV_WMASK;
        rimb_pkg::OFS_LIN:  lin_next  = rx_byte & rimb_pkg::LIN_WMASK;
        default:            top2_next = top2_reg;
      endcase
    end
    // set beats clear
    rflag_next = (rflag_reg & ~reset_reg_clr_i)
               | (reg_reset_evt_i & ~top2_reg[rimb_pkg::RST_MASK_BIT]);
  end

  // a host write to top2 bit 0 only lasts until the next reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      top2_reg  <= {rimb_pkg::TOP2_RST_HI, otp_rst_mask_i};
      conv_reg  <= rimb_pkg::CONV_RST;
      lin_reg   <= rimb_pkg::LIN_RST;
      rflag_reg <= 1'b0;
    end else begin
      top2_reg  <= top2_next;
      conv_reg  <= conv_next;
      lin_reg   <= lin_next;
      rflag_reg <= rflag_next;
    end
  end

  assign reset_reg_irq_flag_o = rflag_reg;

  // rail order: conv0, conv1, lin0, lin1
  assign pg_valid = {lin1_pg_valid_i, lin0_pg_valid_i, conv1_pg_valid_i, conv0_pg_valid_i};
  assign curlim   = {lin1_curlim_i, lin0_curlim_i, conv1_curlim_i, conv0_curlim_i};
  assign pg_clr   = {lin1_pg_clr_i, lin0_pg_clr_i, conv1_pg_clr_i, conv0_pg_clr_i};
  assign lim_clr  = {lin1_curlim_clr_i, lin0_curlim_clr_i,
                     conv1_curlim_clr_i, conv0_curlim_clr_i};

  // mask fields routed to rails
  assign fall_blk[0] = conv_reg[rimb_pkg::R0_FALL_BIT];
  assign fall_blk[1] = conv_reg[rimb_pkg::R1_FALL_BIT];
  assign fall_blk[2] = lin_reg[rimb_pkg::R0_FALL_BIT];
  assign fall_blk[3] = lin_reg[rimb_pkg::R1_FALL_BIT];
  assign rise_blk[0] = conv_reg[rimb_pkg::R0_RISE_BIT];
  assign rise_blk[1] = conv_reg[rimb_pkg::R1_RISE_BIT];
  assign rise_blk[2] = lin_reg[rimb_pkg::R0_RISE_BIT];
  assign rise_blk[3] = lin_reg[rimb_pkg::R1_RISE_BIT];
  assign lim_blk[0]  = conv_reg[rimb_pkg::R0_ILIM_BIT];
  assign lim_blk[1]  = conv_reg[rimb_pkg::R1_ILIM_BIT];
  assign lim_blk[2]  = lin_reg[rimb_pkg::R0_ILIM_BIT];
  assign lim_blk[3]  = lin_reg[rimb_pkg::R1_ILIM_BIT];

  // one tracker per rail
  for (genvar g = 0; g < 4; g++) begin : g_rail
    rimb_rail_evt u_rail (
      .clk_i          (clk_i),
      .srst_i         (srst_i),
      .pg_valid_i     (pg_valid[g]),
      .curlim_i       (curlim[g]),
      .fall_block_i   (fall_blk[g]),
      .rise_block_i   (rise_blk[g]),
      .curlim_block_i (lim_blk[g]),
      .pg_clr_i       (pg_clr[g]),
      .curlim_clr_i   (lim_clr[g]),
      .pg_raw_o       (pg_raw[g]),
      .curlim_raw_o   (lim_raw[g]),
      .pg_flag_o      (pg_flag[g]),
      .curlim_flag_o  (lim_flag[g])
    );
  end

  // raw status and flags out
  assign conv0_pg_raw_o          = pg_raw[0];
  assign conv1_pg_raw_o          = pg_raw[1];
  assign lin0_pg_raw_o           = pg_raw[2];
  assign lin1_pg_raw_o           = pg_raw[3];
  assign conv0_curlim_raw_o      = lim_raw[0];
  assign conv1_curlim_raw_o      = lim_raw[1];
  assign lin0_curlim_raw_o       = lim_raw[2];
  assign lin1_curlim_raw_o       = lim_raw[3];
  assign conv0_pg_irq_flag_o     = pg_flag[0];
  assign conv1_pg_irq_flag_o     = pg_flag[1];
  assign lin0_pg_irq_flag_o      = pg_flag[2];
  assign lin1_pg_irq_flag_o      = pg_flag[3];
  assign conv0_curlim_irq_flag_o = lim_flag[0];
  assign conv1_curlim_irq_flag_o = lim_flag[1];
  assign lin0_curlim_irq_flag_o  = lim_flag[2];
  assign lin1_curlim_irq_flag_o  = lim_flag[3];

endmodule

// >>> verif/rimb_top_props.sv
// port-level checker for the regulator irq mask bank
`timescale 1ns/10ps
module rimb_top_props (
  // clock, reset and causes
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic reg_reset_evt_i,
  input wire logic conv0_pg_valid_i,
  input wire logic lin1_pg_valid_i,
  input wire logic conv0_curlim_i,
  input wire logic conv0_pg_clr_i,
  // observed status and flags
  input wire logic conv0_pg_raw_o,
  input wire logic lin1_pg_raw_o,
  input wire logic conv0_curlim_raw_o,
  input wire logic conv1_curlim_raw_o,
  input wire logic conv0_pg_irq_flag_o,
  input wire logic lin1_pg_irq_flag_o,
  input wire logic conv1_curlim_irq_flag_o,
  input wire logic reset_reg_irq_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // raw status must follow the rail whatever the masks say; skip edge after reset
  a_pg0_raw_track: assert property (
    !$past(srst_i) |-> conv0_pg_raw_o == !$past(conv0_pg_valid_i))
    else $error("conv0 raw power-good wrong");
  a_lin1_raw_track: assert property (
    !$past(srst_i) |-> lin1_pg_raw_o == !$past(lin1_pg_valid_i))
    else $error("lin1 raw power-good wrong");
  a_cl0_raw_track: assert property (
    !$past(srst_i) |-> conv0_curlim_raw_o == $past(conv0_curlim_i))
    else $error("conv0 raw current limit wrong");
  // a rail flag may only rise together with a transition of its raw bit, the reset flag only after an event; the conv0 pg flag holds until cleared
  a_pg0_flag_cause: assert property (
    $rose(conv0_pg_irq_flag_o) |-> $changed(conv0_pg_raw_o))
    else $error("conv0 pg flag without transition");
  a_lin1_flag_cause: assert property (
    $rose(lin1_pg_irq_flag_o) |-> $changed(lin1_pg_raw_o))
    else $error("lin1 pg flag without transition");
  a_cl1_flag_cause: assert property (
    $rose(conv1_curlim_irq_flag_o) |-> $rose(conv1_curlim_raw_o))
    else $error("conv1 limit flag without onset");
  a_rst_flag_cause: assert property (
    $rose(reset_reg_irq_flag_o) |-> $past(reg_reset_evt_i))
    else $error("reset flag without event");
  a_pg0_flag_hold: assert property (
    conv0_pg_irq_flag_o && !conv0_pg_clr_i |=> conv0_pg_irq_flag_o)
    else $error("conv0 pg flag lost without clear");
endmodule

bind rimb_top rimb_top_props rimb_top_props_inst (
  .clk_i, .srst_i, .reg_reset_evt_i, .conv0_pg_valid_i, .lin1_pg_valid_i,
  .conv0_curlim_i, .conv0_pg_clr_i, .conv0_pg_raw_o, .lin1_pg_raw_o,
  .conv0_curlim_raw_o, .conv1_curlim_raw_o, .conv0_pg_irq_flag_o,
  .lin1_pg_irq_flag_o, .conv1_curlim_irq_flag_o, .reset_reg_irq_flag_o
);

// >>> verif/rimb_host_model.sv
// serial bus controller model that reaches the mask registers
`timescale 1ns/10ps
module rimb_host_model (
  // clock
  input  wire logic clk_i,
  // serial bus, open drain data
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  // idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // all pin changes land on falling edges, well clear of sampling
  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // one bit; data moves mid-low so it is stable around both clock edges
  task automatic bit_x(input logic b, output logic r);
    sda_oe_o = !b;
    gap(2);
    scl_o = 1'b1;
    gap(2);
    r = sda_i;
    scl_o = 1'b0;
    gap(1);
  endtask

  // start or repeated start, leaves the clock low
  task automatic start;
    sda_oe_o = 1'b0;
    gap(2);
    scl_o = 1'b1;
    gap(2);
    sda_oe_o = 1'b1;
    gap(2);
    scl_o = 1'b0;
    gap(1);
  endtask

  // stop condition, bus left idle
  task automatic stop;
    sda_oe_o = 1'b1;
    gap(2);
    scl_o = 1'b1;
    gap(2);
    sda_oe_o = 1'b0;
    gap(2);
  endtask

  // byte out, msb first; ok drops on a missing ack
  task automatic put(input logic [7:0] d, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ok = ok & !r;
  endtask

  // byte in; the last byte is refused so the target lets go
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask

  // write one or two bytes from pointer p
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                    input int n, output logic ok);
    ok = 1'b1;
    start;
    put({a, 1'b0}, ok);
    put(p, ok);
    if (n == 2) put(d[15:8], ok);
    put(d[7:0], ok);
    stop;
  endtask

  // read one or two bytes from pointer p, first byte ends up high
  task automatic rd(input logic [7:0] p, input int n, output logic [15:0] d);
    logic       ok;
    logic [7:0] b;
    ok = 1'b1;
    d = 16'h0000;
    start;
    put({rimb_pkg::DEV_ADDR, 1'b0}, ok);
    put(p, ok);
    start;
    put({rimb_pkg::DEV_ADDR, 1'b1}, ok);
    for (int i = n; i > 0; i--) begin
      get(i == 1, b);
      d = {d[7:0], b};
    end
    stop;
  endtask
endmodule

// >>> verif/regulator_irq_mask_bank_tb.sv
// self-checking bench for the regulator irq mask bank
`timescale 1ns/10ps
module regulator_irq_mask_bank_tb;
  // stimulus; rail vectors: bit 0 conv0, 1 conv1, 2 lin0, 3 lin1
  localparam int MAX_CYC = 40000;
  logic        clk  = 1'b0;
  logic        srst = 1'b1;
  logic        otp  = 1'b1;
  logic        evt  = 1'b0;
  logic        rclr = 1'b0;
  logic [3:0]  pv   = 4'hF;
  logic [3:0]  cl   = 4'h0;
  logic [3:0]  pclr = 4'h0;
  logic [3:0]  cclr = 4'h0;
  logic        ok;
  logic [15:0] rv;
  wire  [3:0]  praw, craw, pflg, cflg;
  wire         rflg, dsda, doe, hscl, hoe, sda;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // wired data line with pull-up
  assign sda = !(hoe | (doe & !dsda));

  initial forever #25 clk = ~clk;

  rimb_top rimb_top_inst (
    .clk_i(clk), .srst_i(srst), .scl_i(hscl), .sda_i(sda), .sda_o(dsda), .sda_oe_o(doe),
    .otp_rst_mask_i(otp), .reg_reset_evt_i(evt), .reset_reg_clr_i(rclr),
    .conv0_pg_valid_i(pv[0]), .conv1_pg_valid_i(pv[1]),
    .lin0_pg_valid_i(pv[2]), .lin1_pg_valid_i(pv[3]),
    .conv0_curlim_i(cl[0]), .conv1_curlim_i(cl[1]), .lin0_curlim_i(cl[2]), .lin1_curlim_i(cl[3]),
    .conv0_pg_clr_i(pclr[0]), .conv1_pg_clr_i(pclr[1]),
    .lin0_pg_clr_i(pclr[2]), .lin1_pg_clr_i(pclr[3]),
    .conv0_curlim_clr_i(cclr[0]), .conv1_curlim_clr_i(cclr[1]),
    .lin0_curlim_clr_i(cclr[2]), .lin1_curlim_clr_i(cclr[3]),
    .conv0_pg_raw_o(praw[0]), .conv1_pg_raw_o(praw[1]),
    .lin0_pg_raw_o(praw[2]), .lin1_pg_raw_o(praw[3]),
    .conv0_curlim_raw_o(craw[0]), .conv1_curlim_raw_o(craw[1]),
    .lin0_curlim_raw_o(craw[2]), .lin1_curlim_raw_o(craw[3]),
    .conv0_pg_irq_flag_o(pflg[0]), .conv1_pg_irq_flag_o(pflg[1]),
    .lin0_pg_irq_flag_o(pflg[2]), .lin1_pg_irq_flag_o(pflg[3]),
    .conv0_curlim_irq_flag_o(cflg[0]), .conv1_curlim_irq_flag_o(cflg[1]),
    .lin0_curlim_irq_flag_o(cflg[2]), .lin1_curlim_irq_flag_o(cflg[3]),
    .reset_reg_irq_flag_o(rflg)
  );

  rimb_host_model rimb_host_model_inst (.clk_i(clk), .scl_o(hscl), .sda_oe_o(hoe), .sda_i(sda));

  // shared compare, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask

  task automatic final_report;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, several times the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == MAX_CYC) begin
      errors++;
      final_report;
    end
  end

  task automatic reset_dut(input logic o);
    otp = o;
    srst = 1'b1;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [7:0] p, input int n, input logic [15:0] e);
    rimb_host_model_inst.rd(p, n, rv);
    chk(rv, e, "register read");
  endtask

  task automatic wrc(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d,
                     input int n, input logic e);
    rimb_host_model_inst.wr(a, p, d, n, ok);
    chk({15'h0000, ok}, {15'h0000, e}, "target ack");
  endtask

  // rail step: raw must follow, flags only where unmasked; then flags cleared
  task automatic step(input logic [3:0] v, input logic [3:0] c,
                      input logic [3:0] ep, input logic [3:0] ec);
    pv = v;
    cl = c;
    @(negedge clk);
    chk({praw, craw, pflg, cflg}, {~v, c, ep, ec}, "rail status");
    pclr = 4'hF;
    cclr = 4'hF;
    @(negedge clk);
    pclr = 4'h0;
    cclr = 4'h0;
    @(negedge clk);
  endtask

  // register-reset event, expecting the flag or not
  task automatic pulse(input logic e);
    evt = 1'b1;
    @(negedge clk);
    evt = 1'b0;
    @(negedge clk);
    chk({15'h0000, rflg}, {15'h0000, e}, "reset flag");
    rclr = 1'b1;
    @(negedge clk);
    rclr = 1'b0;
    // clear must really drop the flag, or a later reset would hide it
    chk({15'h0000, rflg}, 16'h0000, "reset flag clear");
  endtask

  task automatic t_defaults;
    rdc(rimb_pkg::OFS_TOP2, 1, 16'h0001);
    rdc(rimb_pkg::OFS_CONV, 2, 16'hDDDD);
  endtask

  // burst write, reserved bits, unmapped place, foreign address
  task automatic t_regs;
    wrc(rimb_pkg::DEV_ADDR, rimb_pkg::OFS_CONV, 16'hFFFF, 2, 1'b1);
    rdc(rimb_pkg::OFS_CONV, 2, 16'hDDDD);
    wrc(rimb_pkg::DEV_ADDR, 8'h30, 16'h0055, 1, 1'b1);
    rdc(8'h30, 1, 16'h0000);
    wrc(rimb_pkg::DEV_ADDR ^ 7'h01, rimb_pkg::OFS_CONV, 16'h0000, 2, 1'b0);
    rdc(rimb_pkg::OFS_CONV, 2, 16'hDDDD);
  endtask

  // each mask direction blocked, then allowed
  task automatic t_masks;
    wrc(rimb_pkg::DEV_ADDR, rimb_pkg::OFS_CONV, 16'hDDDD, 2, 1'b1);
    step(4'h0, 4'hF, 4'h0, 4'h0);
    step(4'hF, 4'h0, 4'h0, 4'h0);
    wrc(rimb_pkg::DEV_ADDR, rimb_pkg::OFS_CONV, 16'h5555, 2, 1'b1);
    step(4'h0, 4'hF, 4'hF, 4'h0);
    step(4'hF, 4'h0, 4'h0, 4'h0);
    wrc(rimb_pkg::DEV_ADDR, rimb_pkg::OFS_CONV, 16'h8888, 2, 1'b1);
    step(4'h0, 4'hF, 4'h0, 4'hF);
    step(4'hF, 4'h0, 4'hF, 4'h0);
  endtask

  // host write lasts only until the next reset reloads otp
  task automatic t_rst_mask;
    wrc(rimb_pkg::DEV_ADDR, rimb_pkg::OFS_TOP2, 16'h00FE, 1, 1'b1);
    rdc(rimb_pkg::OFS_TOP2, 1, 16'h00FE);
    pulse(1'b1);
    // event and clear in one cycle: the set must win
    evt  = 1'b1;
    rclr = 1'b1;
    @(negedge clk);
    evt  = 1'b0;
    rclr = 1'b0;
    chk({15'h0000, rflg}, 16'h0001, "set beats clear");
    reset_dut(1'b1);
    rdc(rimb_pkg::OFS_TOP2, 1, 16'h0001);
    pulse(1'b0);
    reset_dut(1'b0);
    rdc(rimb_pkg::OFS_TOP2, 1, 16'h0000);
    pulse(1'b1);
  endtask

  // main sequence
  initial begin
    reset_dut(1'b1);
    t_defaults;
    t_regs;
    t_masks;
    t_rst_mask;
    final_report;
  end
endmodule
